// File: verilog/icp_top.sv
`timescale 1ns/10ps
module icp_top import icp_pkg::*; #(
  parameter int N_EXT = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ICP_NSRC-1:0] periph_req, // peripheral set pulses
  input wire logic [N_EXT-1:0] ext_req, // external request pins
  input wire logic [ICP_TRAP_W-1:0] trap_evt, // trap event pulses
  input wire logic cpu_level_high_bit, // driven by the core
  input wire logic cpu_ack, // core takes the latched vector
  output logic int_req, // request to the core
  output logic [6:0] int_vec, // latched vector number
  output logic [3:0] int_lvl, // latched new level
  output logic [3:0] cpu_level, // effective cpu level
  output logic alt_vec, // alternate table select
  output logic irq // level interrupt for software events
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (N_EXT < 1 || N_EXT > 16) begin : g_bad_ext
    $error("N_EXT must lie between 1 and 16");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [15:0] ctl1_r, ctl1_nxt; // global_control_one
  logic [15:0] ctl2_r, ctl2_nxt; // global_control_two
  logic [15:0] flag_r [ICP_NBANK]; // request_flag_regs
  logic [15:0] flag_nxt [ICP_NBANK];
  logic [15:0] en_r [ICP_NBANK]; // source_enable_regs
  logic [15:0] en_nxt [ICP_NBANK];
  logic [15:0] ipc_r [ICP_NIPC]; // source_priority_regs
  logic [15:0] ipc_nxt [ICP_NIPC];
  logic [6:0] vec_r, vec_nxt; // pending_vector_number
  logic [3:0] ilr_r, ilr_nxt; // new_cpu_level
  logic req_r, req_nxt; // a winner is latched
  logic [2:0] lvl_r, lvl_nxt; // cpu_level_field
  logic hi_r, hi_nxt; // cpu_level_high_bit copy
  logic [ICP_EV_W-1:0] ist_r, ist_nxt; // sticky events
  logic [ICP_EV_W-1:0] ien_r, ien_nxt; // event enables
  logic irq_r, irq_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic rdy_r, rdy_nxt;
  logic err_r, err_nxt;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [N_EXT-1:0] ext_pulse; // accepted external edges
  logic [ICP_NSRC-1:0] pend; // flag and enable both set
  logic [3*ICP_NSRC-1:0] prio_flat;
  logic win_valid;
  logic [6:0] win_vec;
  logic [2:0] win_prio;
  logic setup, acc_wr;
  logic [ICP_NSRC-1:0] set_vec; // hardware set requests

  // address of a 32-bit word inside a block of consecutive words
  function automatic logic in_blk(input logic [7:0] a, input logic [7:0] base,
                                  input int cnt);
    in_blk = a[1:0] == 2'b00 && a >= base && int'(a - base) < 4 * cnt;
  endfunction

  // word index inside such a block
  function automatic int blk_idx(input logic [7:0] a, input logic [7:0] base);
    blk_idx = int'(a - base) >> 2;
  endfunction

  // does the address hit one of the mapped registers
  function automatic logic hit(input logic [7:0] a);
    hit = a == ICP_OFF_CTL1 || a == ICP_OFF_CTL2 ||
          in_blk(a, ICP_OFF_FLAG0, ICP_NBANK) ||
          in_blk(a, ICP_OFF_EN0, ICP_NBANK) ||
          (in_blk(a, ICP_OFF_IPC0, ICP_NIPC) &&
           ICP_IPC_IMPL[blk_idx(a, ICP_OFF_IPC0)]) ||
          a == ICP_OFF_LATCH || a == ICP_OFF_SR || a == ICP_OFF_CORE ||
          a == ICP_OFF_IST || a == ICP_OFF_ICLR || a == ICP_OFF_IEN;
  endfunction

  // ----------------------------------------
  // external pins and arbitration
  // ----------------------------------------
  icp_edge_sync #(.W(N_EXT)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_raw(ext_req),
    .fall_sel(ctl2_r[N_EXT-1:0]),
    .edge_pulse(ext_pulse)
  );

  // source s sits at bank s/16 bit s%16 and priority word s/4
  always_comb begin
    for (int s = 0; s < ICP_NSRC; s++) begin
      pend[s] = flag_r[s / 16][s % 16] & en_r[s / 16][s % 16];
      prio_flat[3*s +: 3] = ipc_r[s / 4][4*(s % 4) +: 3];
    end
  end

  icp_arbiter #(.N(ICP_NSRC)) u_arb (
    .req(pend),
    .prio(prio_flat),
    .cur_level({hi_r, lvl_r}),
    .win_valid(win_valid),
    .win_vec(win_vec),
    .win_prio(win_prio)
  );

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // the slave answers one cycle after setup, so no access has a wait state
  assign setup = psel & ~penable;
  assign acc_wr = psel & penable & rdy_r & pwrite & hit(paddr);
  assign set_vec = periph_req | {{(ICP_NSRC - N_EXT){1'b0}}, ext_pulse};

  // ----------------------------------------
  // next state of the whole register file
  // ----------------------------------------
  always_comb begin
    logic [ICP_EV_W-1:0] ev;
    logic [ICP_EV_W-1:0] clr;
    logic [15:0] rd;
    ev = '0;
    clr = '0;
    rd = '0;
    ctl1_nxt = ctl1_r;
    ctl2_nxt = ctl2_r;
    flag_nxt = flag_r;
    en_nxt = en_r;
    ipc_nxt = ipc_r;
    lvl_nxt = lvl_r;
    ien_nxt = ien_r;
    hi_nxt = cpu_level_high_bit;
    // software writes first, hardware sets after, so a set wins
    if (acc_wr) begin
      if (paddr == ICP_OFF_CTL1) begin
        ctl1_nxt = pwdata[15:0];
      end
      if (paddr == ICP_OFF_CTL2) begin
        ctl2_nxt = pwdata[15:0];
      end
      if (in_blk(paddr, ICP_OFF_FLAG0, ICP_NBANK)) begin
        flag_nxt[blk_idx(paddr, ICP_OFF_FLAG0)] = pwdata[15:0];
      end
      if (in_blk(paddr, ICP_OFF_EN0, ICP_NBANK)) begin
        en_nxt[blk_idx(paddr, ICP_OFF_EN0)] = pwdata[15:0];
      end
      if (in_blk(paddr, ICP_OFF_IPC0, ICP_NIPC)) begin
        ipc_nxt[blk_idx(paddr, ICP_OFF_IPC0)] = pwdata[15:0] & ICP_IPC_MASK;
      end
      // level field frozen for software while nesting is disabled
      if (paddr == ICP_OFF_SR && !ctl1_r[ICP_NEST_BIT]) begin
        lvl_nxt = pwdata[ICP_LVL_LSB +: 3];
      end
      if (paddr == ICP_OFF_ICLR) begin
        clr = pwdata[ICP_EV_W-1:0];
      end
      if (paddr == ICP_OFF_IEN) begin
        ien_nxt = pwdata[ICP_EV_W-1:0];
      end
    end
    // the core raising its level on acceptance is not a software write
    if (cpu_ack && req_r) begin
      lvl_nxt = ilr_r[2:0];
    end
    // hardware set of request and trap flags
    for (int b = 0; b < ICP_NBANK; b++) begin
      flag_nxt[b] = flag_nxt[b] | set_vec[16*b +: 16];
    end
    ctl1_nxt[ICP_TRAP_LSB +: ICP_TRAP_W] =
      ctl1_nxt[ICP_TRAP_LSB +: ICP_TRAP_W] | trap_evt;
    // unimplemented priority words keep no state
    for (int i = 0; i < ICP_NIPC; i++) begin
      if (!ICP_IPC_IMPL[i]) begin
        ipc_nxt[i] = ICP_RST16;
      end
    end
    // latch the winner while one exists
    req_nxt = win_valid;
    vec_nxt = win_valid ? win_vec : vec_r;
    ilr_nxt = win_valid ? {1'b0, win_prio} : ilr_r;
    // sticky events: set beats clear
    ev[ICP_EV_VEC] = win_valid & ~req_r;
    ev[ICP_EV_TRAP] = |trap_evt;
    ev[ICP_EV_ERR] = setup & ~hit(paddr);
    ist_nxt = (ist_r & ~clr) | ev;
    irq_nxt = |(ist_r & ien_r);
    // read data captured in the setup cycle
    if (paddr == ICP_OFF_CTL1) begin
      rd = ctl1_r;
    end else if (paddr == ICP_OFF_CTL2) begin
      rd = ctl2_r;
    end else if (in_blk(paddr, ICP_OFF_FLAG0, ICP_NBANK)) begin
      rd = flag_r[blk_idx(paddr, ICP_OFF_FLAG0)];
    end else if (in_blk(paddr, ICP_OFF_EN0, ICP_NBANK)) begin
      rd = en_r[blk_idx(paddr, ICP_OFF_EN0)];
    end else if (in_blk(paddr, ICP_OFF_IPC0, ICP_NIPC)) begin
      rd = ipc_r[blk_idx(paddr, ICP_OFF_IPC0)];
    end else if (paddr == ICP_OFF_LATCH) begin
      rd[ICP_VEC_LSB +: 7] = vec_r;
      rd[ICP_ILR_LSB +: 4] = ilr_r;
    end else if (paddr == ICP_OFF_SR) begin
      rd[ICP_LVL_LSB +: 3] = lvl_r;
    end else if (paddr == ICP_OFF_CORE) begin
      rd[ICP_HI_BIT] = hi_r;
    end else if (paddr == ICP_OFF_IST) begin
      rd[ICP_EV_W-1:0] = ist_r;
    end else if (paddr == ICP_OFF_IEN) begin
      rd[ICP_EV_W-1:0] = ien_r;
    end
    rdy_nxt = setup;
    err_nxt = setup & ~hit(paddr);
    rdata_nxt = (setup && !pwrite) ? {16'h0000, rd} : rdata_r;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1_r <= ICP_RST16;
      ctl2_r <= ICP_RST16;
      for (int b = 0; b < ICP_NBANK; b++) begin
        flag_r[b] <= ICP_RST16;
        en_r[b] <= ICP_RST16;
      end
      for (int i = 0; i < ICP_NIPC; i++) begin
        ipc_r[i] <= ICP_RST16;
      end
      vec_r <= '0;
      ilr_r <= '0;
      req_r <= 1'b0;
      lvl_r <= '0;
      hi_r <= 1'b0;
      ist_r <= '0;
      ien_r <= '0;
      irq_r <= 1'b0;
      rdata_r <= '0;
      rdy_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      ctl1_r <= ctl1_nxt;
      ctl2_r <= ctl2_nxt;
      flag_r <= flag_nxt;
      en_r <= en_nxt;
      ipc_r <= ipc_nxt;
      vec_r <= vec_nxt;
      ilr_r <= ilr_nxt;
      req_r <= req_nxt;
      lvl_r <= lvl_nxt;
      hi_r <= hi_nxt;
      ist_r <= ist_nxt;
      ien_r <= ien_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
      rdy_r <= rdy_nxt;
      err_r <= err_nxt;
    end
  end

  // ----------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------
  assign prdata = rdata_r;
  assign pready = rdy_r;
  assign pslverr = err_r; // err_r only rises together with rdy_r
  assign int_req = req_r;
  assign int_vec = vec_r;
  assign int_lvl = ilr_r;
  assign cpu_level = {hi_r, lvl_r};
  assign alt_vec = ctl2_r[ICP_AIV_BIT];
  assign irq = irq_r;
endmodule // icp_top

// File: common/icp_pkg.sv
// ----------------------------------------
// interrupt controller constants
// ----------------------------------------
package icp_pkg;
  // sizes
  localparam int ICP_NSRC = 64; // sources held in the flag banks
  localparam int ICP_NBANK = 4; // flag and enable words
  localparam int ICP_NIPC = 20; // priority word indices
  localparam int ICP_TRAP_W = 4; // trap flags in control one
  localparam int ICP_EV_W = 3; // sticky event bits
  // byte offsets on the register bus
  localparam logic [7:0] ICP_OFF_CTL1 = 8'h00;
  localparam logic [7:0] ICP_OFF_CTL2 = 8'h04;
  localparam logic [7:0] ICP_OFF_FLAG0 = 8'h10;
  localparam logic [7:0] ICP_OFF_EN0 = 8'h20;
  localparam logic [7:0] ICP_OFF_IPC0 = 8'h40;
  localparam logic [7:0] ICP_OFF_LATCH = 8'h90;
  localparam logic [7:0] ICP_OFF_SR = 8'h94;
  localparam logic [7:0] ICP_OFF_CORE = 8'h98;
  localparam logic [7:0] ICP_OFF_IST = 8'hA0;
  localparam logic [7:0] ICP_OFF_ICLR = 8'hA4;
  localparam logic [7:0] ICP_OFF_IEN = 8'hA8;
  // priority words that exist: 0..5, 7, 15..19
  localparam logic [19:0] ICP_IPC_IMPL = 20'hF80BF;
  // field positions
  localparam int ICP_NEST_BIT = 15; // nesting_disable in control one
  localparam int ICP_TRAP_LSB = 1; // trap flags in control one
  localparam int ICP_AIV_BIT = 15; // alternate_vector_table
  localparam int ICP_LVL_LSB = 5; // cpu_level_field in status
  localparam int ICP_HI_BIT = 3; // cpu_level_high_bit in core control
  localparam int ICP_VEC_LSB = 0; // pending_vector_number
  localparam int ICP_ILR_LSB = 8; // new_cpu_level
  localparam logic [15:0] ICP_IPC_MASK = 16'h7777; // four 3-bit fields
  // sticky events
  localparam int ICP_EV_VEC = 0; // a new vector was latched
  localparam int ICP_EV_TRAP = 1; // a trap flag was set
  localparam int ICP_EV_ERR = 2; // unmapped bus access
  // reset values
  localparam logic [15:0] ICP_RST16 = 16'h0000;
endpackage

// File: verilog/icp_edge_sync.sv
`timescale 1ns/10ps
// ----------------------------------------
// pin synchroniser with edge select
// ----------------------------------------
module icp_edge_sync #(
  parameter int W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] pin_raw, // asynchronous request pins
  input wire logic [W-1:0] fall_sel, // 1 = falling edge requests
  output logic [W-1:0] edge_pulse // one cycle per accepted edge of the selected direction
);
  logic [W-1:0] s1_r, s2_r, s3_r; // three-stage chain
  logic [W-1:0] lvl_r, lvl_nxt; // accepted pin level
  logic [W-1:0] pulse_r, pulse_nxt;

  // a change counts only once stages two and three agree
  always_comb begin
    lvl_nxt = lvl_r;
    pulse_nxt = '0;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i] && s3_r[i] != lvl_r[i]) begin
        lvl_nxt[i] = s3_r[i];
        pulse_nxt[i] = s3_r[i] ^ fall_sel[i];
      end
    end
  end

  // s1 feeds only s2, so no logic looks at a metastable stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
      pulse_r <= '0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign edge_pulse = pulse_r;
endmodule // icp_edge_sync

// File: verilog/icp_arbiter.sv
`timescale 1ns/10ps
// ----------------------------------------
// priority arbiter, purely combinational
// ----------------------------------------
module icp_arbiter import icp_pkg::*; #(
  parameter int N = ICP_NSRC
) (
  input wire logic [N-1:0] req, // flag and enable both set
  input wire logic [3*N-1:0] prio, // 3-bit priority per source
  input wire logic [3:0] cur_level, // effective cpu level
  output logic win_valid, // some source beats the cpu level
  output logic [6:0] win_vec, // winning vector number
  output logic [2:0] win_prio // winning priority
);
  // walk downwards and take ties, so the lowest vector wins a tie
  always_comb begin
    win_valid = 1'b0;
    win_vec = '0;
    win_prio = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && {1'b0, prio[3*i +: 3]} > cur_level &&
          (!win_valid || prio[3*i +: 3] >= win_prio)) begin
        win_valid = 1'b1;
        win_vec = 7'(i);
        win_prio = prio[3*i +: 3];
      end
    end
  end
endmodule // icp_arbiter

// File: verif/icp_top_props.sv
`timescale 1ns/10ps
// ----------------------------------------
// port checker for the interrupt controller
// ----------------------------------------
module icp_top_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_level_high_bit,
  input wire logic int_req,
  input wire logic [3:0] int_lvl,
  input wire logic [3:0] cpu_level
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb phases as the bus sees them
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence
  a_ready_one: assert property (s_setup |=> s_answer)
    else $error("no answer one cycle after setup");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  // priority zero never wins, so a request always carries a level of 1..7
  a_lvl_form: assert property (int_req |-> !int_lvl[3] && int_lvl[2:0] != 3'h0)
    else $error("bad latched level");
  a_req_above: assert property ($rose(int_req) && $stable(cpu_level) |-> int_lvl > cpu_level)
    else $error("request not above cpu level");
  a_seven_masks: assert property ((cpu_level[2:0] == 3'h7) [*2] |=> !int_req)
    else $error("request at level seven");
  // up to three register stages are allowed before the high bit shows
  a_high_bit: assert property ($stable(cpu_level_high_bit) [*3] |->
    cpu_level[3] == cpu_level_high_bit)
    else $error("high level bit not followed");
endmodule // icp_top_props

bind icp_top icp_top_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .cpu_level_high_bit, .int_req, .int_lvl, .cpu_level);

// File: verif/icp_core_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// cpu core stand-in
// ----------------------------------------
module icp_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic int_req,
  input wire logic ack_en, // bench lets the core take vectors
  input wire logic hi_in, // trap level asked for by the bench
  output logic cpu_ack,
  output logic cpu_level_high_bit
);
  logic ack_r, ack_nxt; // one-cycle take pulse
  // take a pending vector, never twice in a row
  always_comb begin
    ack_nxt = ack_en && int_req && !ack_r;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end
  assign cpu_ack = ack_r;
  assign cpu_level_high_bit = hi_in;
endmodule // icp_core_model

// File: verif/icp_top_test.sv
`timescale 1ns/10ps
module icp_top_test import icp_pkg::*;;
  // ----------------------------------------
  // stimulus and design
  // ----------------------------------------
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ack_en = 0, hi_in = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic [63:0] periph_req = 64'h0;
  logic [2:0] ext_req = 3'h0;
  logic [3:0] trap_evt = 4'h0, int_lvl, cpu_level;
  logic [6:0] int_vec;
  logic pready, pslverr, cpu_ack, cpu_level_high_bit, int_req, alt_vec, irq, err_q;
  int err_count = 0, total_checks = 0, cyc = 0;
  always #20 pclk = ~pclk;
  icp_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .periph_req, .ext_req, .trap_evt, .cpu_level_high_bit, .cpu_ack, .int_req,
    .int_vec, .int_lvl, .cpu_level, .alt_vec, .irq);
  icp_core_model core (.pclk, .presetn, .int_req, .ack_en, .hi_in, .cpu_ack,
    .cpu_level_high_bit);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      err_count++;
    end
  endtask
  // one apb transfer; an idle edge follows so the next setup never collides
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 16'h0000);
    chk("read data", rd_q, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdchk(ICP_OFF_CTL1, 32'h0);
    rdchk(ICP_OFF_LATCH, 32'h0);
    apb(1'b0, 8'hFC, 16'h0);
    chk("unmapped error", {31'h0, err_q}, 32'h1);
    chk("unmapped data", rd_q, 32'h0);
  endtask
  task automatic t_flags;
    periph_req <= 64'h0000_0002_0000_0020; // sources 5 and 33
    settle(1);
    periph_req <= 64'h0;
    rdchk(ICP_OFF_FLAG0, 32'h20);
    rdchk(ICP_OFF_FLAG0 + 8'h08, 32'h2);
    apb(1'b1, ICP_OFF_FLAG0, 16'h0);
    rdchk(ICP_OFF_FLAG0, 32'h0);
  endtask
  task automatic t_arb;
    apb(1'b1, ICP_OFF_IPC0, 16'h0053);
    apb(1'b1, ICP_OFF_EN0, 16'h0003);
    periph_req <= 64'h3;
    settle(1);
    periph_req <= 64'h0;
    settle(2);
    chk("vector", {25'h0, int_vec}, 32'h1);
    chk("level", {28'h0, int_lvl}, 32'h5);
    apb(1'b1, ICP_OFF_IPC0, 16'h0055); // tie goes to the lower vector
    settle(2);
    chk("tie vector", {25'h0, int_vec}, 32'h0);
    apb(1'b1, ICP_OFF_EN0, 16'h0002);
    settle(2);
    chk("masked vector", {25'h0, int_vec}, 32'h1);
    rdchk(ICP_OFF_LATCH, 32'h0501);
  endtask
  task automatic t_level;
    for (int l = 0; l < 8; l++) begin
      apb(1'b1, ICP_OFF_SR, 16'(l << 5));
      settle(2);
      chk("cpu level", {28'h0, cpu_level}, 32'(l));
      chk("request", {31'h0, int_req}, 32'(l < 5));
    end
    apb(1'b1, ICP_OFF_SR, 16'h0000);
  endtask
  task automatic t_high;
    hi_in <= 1'b1;
    settle(3);
    chk("high level", {28'h0, cpu_level}, 32'h8);
    chk("trap masks", {31'h0, int_req}, 32'h0);
    apb(1'b1, ICP_OFF_CORE, 16'h0000);
    rdchk(ICP_OFF_CORE, 32'h8);
    hi_in <= 1'b0;
    settle(3);
  endtask
  task automatic t_nest;
    apb(1'b1, ICP_OFF_SR, 16'h0060);
    apb(1'b1, ICP_OFF_CTL1, 16'h8000);
    apb(1'b1, ICP_OFF_SR, 16'h0020);
    rdchk(ICP_OFF_SR, 32'h60);
    rdchk(ICP_OFF_CTL1, 32'h8000);
    apb(1'b1, ICP_OFF_CTL1, 16'h0000);
    apb(1'b1, ICP_OFF_SR, 16'h0000);
    rdchk(ICP_OFF_SR, 32'h0);
  endtask
  task automatic t_ack;
    ack_en <= 1'b1;
    settle(5);
    ack_en <= 1'b0;
    chk("acked level", {28'h0, cpu_level}, 32'h5);
    chk("request gone", {31'h0, int_req}, 32'h0);
  endtask
  task automatic t_irq;
    // a new vector was latched earlier and the unmapped read raised the bus error
    rdchk(ICP_OFF_IST, 32'h5);
    apb(1'b1, ICP_OFF_ICLR, 16'h0007);
    apb(1'b1, ICP_OFF_IEN, 16'h0002);
    trap_evt <= 4'h4;
    settle(1);
    trap_evt <= 4'h0;
    settle(2);
    chk("irq set", {31'h0, irq}, 32'h1);
    rdchk(ICP_OFF_CTL1, 32'h8);
    // irq is registered from status and enable, so it follows a write one edge later
    apb(1'b1, ICP_OFF_IEN, 16'h0000);
    settle(1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, ICP_OFF_IEN, 16'h0002);
    settle(1);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    apb(1'b1, ICP_OFF_ICLR, 16'h0002);
    settle(1);
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask
  task automatic t_ext;
    apb(1'b1, ICP_OFF_FLAG0, 16'h0);
    apb(1'b1, ICP_OFF_CTL2, 16'h8001); // falling edge on pin 0, rising on pin 1
    chk("alt table", {31'h0, alt_vec}, 32'h1);
    ext_req <= 3'h3;
    settle(8);
    rdchk(ICP_OFF_FLAG0, 32'h2);
    ext_req <= 3'h2;
    settle(8);
    rdchk(ICP_OFF_FLAG0, 32'h3);
  endtask
  // ----------------------------------------
  // verdict and hang guard
  // ----------------------------------------
  task automatic wrap_up;
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    settle(10);
    presetn <= 1'b1;
    settle(1);
    t_reset();
    t_flags();
    t_arb();
    t_level();
    t_high();
    t_nest();
    t_ack();
    t_irq();
    t_ext();
    wrap_up();
  end
endmodule // icp_top_test
